// File: logic/gauge_pkg.sv
// Shared constants and types for the workpiece length gauge
package gauge_pkg;
    localparam int unsigned DATA_W     = 32;
    localparam int unsigned ADDR_W     = 8;
    localparam int unsigned MODE_W     = 3;

    // Register byte addresses
    localparam logic [7:0]  OFS_CTRL   = 8'h00;
    localparam logic [7:0]  OFS_MODE   = 8'h04;
    localparam logic [7:0]  OFS_FILTER = 8'h08;
    localparam logic [7:0]  OFS_STATUS = 8'h0C;
    localparam logic [7:0]  OFS_START  = 8'h10;
    localparam logic [7:0]  OFS_END    = 8'h14;
    localparam logic [7:0]  OFS_COUNT  = 8'h18;

    // Control register fields
    localparam int unsigned CTRL_ARM   = 0;
    localparam int unsigned CTRL_CMP   = 1;
    localparam int unsigned CTRL_SET   = 2;

    // Status register fields
    localparam int unsigned STS_DONE   = 0;
    localparam int unsigned STS_BUSY   = 1;
    localparam int unsigned STS_OUT    = 2;
    localparam int unsigned STS_CFGERR = 3;
    localparam int unsigned STS_BADMOD = 4;

    // Reset values, zero word and last valid mode
    localparam logic [2:0]  CTRL_RST   = 3'h0;
    localparam logic [2:0]  MODE_RST   = 3'h0;
    localparam logic [31:0] FILT_RST   = 32'h0000_0000;
    localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;
    localparam logic [2:0]  MODE_LAST  = 3'h5;

    // Measurement sequencer states
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_START = 4'b0010,
        ST_END   = 4'b0100,
        ST_DONE  = 4'b1000
    } state_type;

    // Odd modes count down
    function automatic logic mode_down(input logic [2:0] m);
        return m[0];
    endfunction

    // Modes 4 and 5 measure only the low level
    function automatic logic mode_low_only(input logic [2:0] m);
        return (m == 3'h4) || (m == 3'h5);
    endfunction

    // Modes 2 and 3 measure only the high level
    function automatic logic mode_high_only(input logic [2:0] m);
        return (m == 3'h2) || (m == 3'h3);
    endfunction
endpackage

// File: logic/filt_if.sv
// Link between the sequencer and the latch edge filter
`timescale 1ns/1ps
interface filt_if;
    logic        level;
    logic        step;
    logic        arm;
    logic [31:0] limit;
    logic [31:0] count;
    logic        fire;
    logic        fire_level;
    logic [31:0] fire_value;
    logic        pending;

    modport filt (input level, step, arm, limit, count,
                  output fire, fire_level, fire_value, pending);
    modport ctl  (output level, step, arm, limit, count,
                  input fire, fire_level, fire_value, pending);
endinterface

// File: logic/latch_filter.sv
// Increment-counted glitch filter with counter snapshot on each edge outside a pending filter interval
`timescale 1ns/1ps
module latch_filter
    import gauge_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    filt_if.filt      fi
);
    logic        prev_r;
    logic        arm_d_r;
    logic        pend_r;
    logic        plevel_r;
    logic [31:0] pval_r;
    logic [31:0] inc_r;
    logic        fire_r;
    logic        flevel_r;
    logic [31:0] fvalue_r;
    logic        edge_seen;
    logic        arm_high;
    logic        expire;

    assign edge_seen = fi.arm && arm_d_r && (fi.level != prev_r);
    assign arm_high  = fi.arm && !arm_d_r && fi.level;
    assign expire    = pend_r && (inc_r >= fi.limit) && !edge_seen;

    ////////////////////////////////////////////////////////////////////////
    // Level history and arm edge
    always_ff @(posedge clk) begin
        if (rst) begin
            prev_r  <= 1'b0;
            arm_d_r <= 1'b0;
        end else begin
            prev_r  <= fi.level;
            arm_d_r <= fi.arm;
        end
    end

    // Snapshot, discard and restart of the filter interval
    always_ff @(posedge clk) begin
        if (rst || !fi.arm) begin
            pend_r   <= 1'b0;
            plevel_r <= 1'b0;
            pval_r   <= ZERO_WORD;
            inc_r    <= ZERO_WORD;
        end else if (edge_seen && pend_r) begin
            pend_r   <= 1'b0;                                   // [RULE_10]
        end else if (edge_seen || arm_high) begin
            pend_r   <= 1'b1;                                   // [RULE_11] [RULE_03]
            plevel_r <= fi.level;
            pval_r   <= fi.count;                               // [RULE_09]
            inc_r    <= ZERO_WORD;
        end else if (expire) begin
            pend_r   <= 1'b0;
        end else if (pend_r && fi.step) begin
            inc_r    <= inc_r + 32'h0000_0001;                  // [RULE_15]
        end
    end

    // Registered expiry event
    always_ff @(posedge clk) begin
        if (rst || !fi.arm) begin
            fire_r   <= 1'b0;
            flevel_r <= 1'b0;
            fvalue_r <= ZERO_WORD;
        end else begin
            fire_r   <= expire;
            if (expire) begin
                flevel_r <= plevel_r;
                fvalue_r <= pval_r;                             // [RULE_09]
            end
        end
    end

    assign fi.fire       = fire_r;
    assign fi.fire_level = flevel_r;
    assign fi.fire_value = fvalue_r;
    assign fi.pending    = pend_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    chk_glitch_drop: assert property (@(posedge clk) disable iff (rst) // [RULE_10]
        (pend_r && edge_seen) |=> !pend_r && !fire_r)
        else $error("edge inside filter interval did not discard");
    chk_fire_after_limit: assert property (@(posedge clk) disable iff (rst) // [RULE_15]
        fire_r |-> $past(pend_r) && ($past(inc_r) >= $past(fi.limit)))
        else $error("filter fired before interval expired");
    chk_fresh_value: assert property (@(posedge clk) disable iff (rst) // [RULE_11]
        (!pend_r && edge_seen) |=> pend_r && (pval_r == $past(fi.count)))
        else $error("new edge did not buffer counter");
endmodule

// File: logic/workpiece_length_gauge.sv
// Workpiece length gauge: APB registers, counter, latch sync and sequencer
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps

// Behaviour
// [RULE_01] Measurement and the threshold output function are never armed together.
// [RULE_02] In modes 0 and 1 a high level starts and its edge count goes to start capture.
// [RULE_03] A latch input already high at arming buffers the counter at once.
// [RULE_04] In modes 0 and 1 a low level ends and its edge count goes to end capture.
// [RULE_05] Completion of any mode sets the measurement-done flag.
// [RULE_06] In modes 2 and 3 the high level capture ends the measurement at once.
// [RULE_07] In modes 4 and 5 only the low level is captured into end capture.
// [RULE_08] Even modes count up and odd modes count down.
// [RULE_09] The captured value is the counter at the edge, not at filter expiry.
// [RULE_10] A level change inside the filter interval discards the buffered value.
// [RULE_11] The next edge after a discard buffers afresh and restarts the interval.
// [RULE_12] In mode 0 the falling edge value goes to end capture before done is set; here end capture and done are written on the same clock edge.
// [RULE_13] The output is driven by the manual bit or by the threshold function.
// [RULE_14] Host arms by setting the arm bit; nothing starts while it is clear.
// [RULE_15] The filter interval is a 32-bit count of encoder increments.
// [RULE_16] Disarming clears the done flag and all buffering.
// [RULE_17] The latch input passes two flip-flops before edge detection.
module workpiece_length_gauge
    import gauge_pkg::*;
(
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [gauge_pkg::ADDR_W-1:0] paddr,
    input  wire logic [gauge_pkg::DATA_W-1:0] pwdata,
    output logic      [gauge_pkg::DATA_W-1:0] prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        latch_in,
    input  wire logic                        enc_step,
    input  wire logic                        cmp_level,
    output logic                             out_drive,
    output logic                             meas_done
);
    import gauge_pkg::*;

    logic [2:0]  ctrl_r;
    logic [2:0]  mode_r;
    logic [31:0] filt_r;
    logic [31:0] start_cap_r;
    logic [31:0] end_cap_r;
    logic [31:0] pos_r;
    logic [31:0] prdata_r;
    logic        sync1_r;
    logic        sync2_r;
    logic        done_r;
    logic        out_r;
    logic        arm_eff;
    logic        mode_ok;
    logic        cfg_err;
    logic        acc;
    logic        mapped;
    logic        hi_fire;
    logic        lo_fire;
    logic [31:0] status_w;
    state_type   state_r;
    state_type   state_nxt;

    filt_if fbus ();

    ////////////////////////////////////////////////////////////////////////
    // APB decode; zero wait states, error on unmapped address
    assign acc     = psel && penable;
    assign mapped  = (paddr == OFS_CTRL) || (paddr == OFS_MODE) ||
                     (paddr == OFS_FILTER) || (paddr == OFS_STATUS) ||
                     (paddr == OFS_START) || (paddr == OFS_END) ||
                     (paddr == OFS_COUNT);
    assign pready  = acc;
    assign pslverr = acc && !mapped;
    assign prdata  = prdata_r;

    // Arming is refused while the threshold output function is enabled
    assign cfg_err = ctrl_r[CTRL_ARM] && ctrl_r[CTRL_CMP];
    assign mode_ok = (mode_r <= MODE_LAST);
    assign arm_eff = ctrl_r[CTRL_ARM] && !ctrl_r[CTRL_CMP] && mode_ok; // [RULE_01] [RULE_14]

    // Status word
    always_comb begin
        status_w             = ZERO_WORD;
        status_w[STS_DONE]   = done_r;
        status_w[STS_BUSY]   = (state_r == ST_START) || (state_r == ST_END);
        status_w[STS_OUT]    = out_r;
        status_w[STS_CFGERR] = cfg_err;
        status_w[STS_BADMOD] = ctrl_r[CTRL_ARM] && !mode_ok;
    end

    // Control registers, written at the access edge
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_r <= CTRL_RST;
            mode_r <= MODE_RST;
            filt_r <= FILT_RST;
        end else if (acc && pwrite) begin
            case (paddr)
                OFS_CTRL: begin
                    ctrl_r <= pwdata[2:0];
                end
                OFS_MODE: begin
                    mode_r <= pwdata[MODE_W-1:0];
                end
                OFS_FILTER: begin
                    filt_r <= pwdata;                           // [RULE_15]
                end
                default: begin
                    ctrl_r <= ctrl_r;
                end
            endcase
        end
    end

    // Read data captured in the setup cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata_r <= ZERO_WORD;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                OFS_CTRL:   prdata_r <= {29'h0, ctrl_r};
                OFS_MODE:   prdata_r <= {29'h0, mode_r};
                OFS_FILTER: prdata_r <= filt_r;
                OFS_STATUS: prdata_r <= status_w;
                OFS_START:  prdata_r <= start_cap_r;
                OFS_END:    prdata_r <= end_cap_r;
                OFS_COUNT:  prdata_r <= pos_r;
                default:    prdata_r <= ZERO_WORD;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Two-stage synchroniser for the latch pin
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= latch_in;                                // [RULE_17]
            sync2_r <= sync1_r;
        end
    end

    // Position counter, direction chosen by mode
    always_ff @(posedge clk) begin
        if (rst) begin
            pos_r <= ZERO_WORD;
        end else if (enc_step) begin
            if (mode_down(mode_r)) begin
                pos_r <= pos_r - 32'h0000_0001;                 // [RULE_08]
            end else begin
                pos_r <= pos_r + 32'h0000_0001;                 // [RULE_08]
            end
        end
    end

    // Output selection: threshold function or manual bit
    always_ff @(posedge clk) begin
        if (rst) begin
            out_r <= 1'b0;
        end else begin
            out_r <= ctrl_r[CTRL_CMP] ? cmp_level : ctrl_r[CTRL_SET]; // [RULE_13]
        end
    end

    assign out_drive = out_r;
    assign meas_done = done_r;

    ////////////////////////////////////////////////////////////////////////
    // Edge filter
    assign fbus.level = sync2_r;
    assign fbus.step  = enc_step;
    assign fbus.arm   = arm_eff;
    assign fbus.limit = filt_r;
    assign fbus.count = pos_r;

    latch_filter u_filter (
        .clk (clk),
        .rst (rst),
        .fi  (fbus)
    );

    assign hi_fire = fbus.fire && fbus.fire_level;
    assign lo_fire = fbus.fire && !fbus.fire_level;

    ////////////////////////////////////////////////////////////////////////
    // Measurement sequencer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (arm_eff) begin
                    state_nxt = mode_low_only(mode_r) ? ST_END : ST_START; // [RULE_07]
                end
            end
            ST_START: begin
                if (hi_fire) begin
                    state_nxt = mode_high_only(mode_r) ? ST_DONE : ST_END; // [RULE_06]
                end
            end
            ST_END: begin
                if (lo_fire) begin
                    state_nxt = ST_DONE;                        // [RULE_04]
                end
            end
            ST_DONE: begin
                state_nxt = ST_DONE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (!arm_eff) begin
            state_nxt = ST_IDLE;                                // [RULE_16]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Capture words take the value buffered at the edge
    always_ff @(posedge clk) begin
        if (rst) begin
            start_cap_r <= ZERO_WORD;
            end_cap_r   <= ZERO_WORD;
        end else if (arm_eff) begin
            if (state_r == ST_START && hi_fire) begin
                start_cap_r <= fbus.fire_value;                 // [RULE_02] [RULE_09]
            end
            if (state_r == ST_END && lo_fire) begin
                end_cap_r <= fbus.fire_value;                   // [RULE_04] [RULE_12]
            end
        end
    end

    // Done flag: set on completion, cleared only by disarm
    always_ff @(posedge clk) begin
        if (rst) begin
            done_r <= 1'b0;
        end else if (state_nxt == ST_DONE) begin
            done_r <= 1'b1;                                     // [RULE_05]
        end else if (!arm_eff) begin
            done_r <= 1'b0;                                     // [RULE_16]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    chk_no_dual_arm: assert property (@(posedge clk) disable iff (rst) // [RULE_01]
        ctrl_r[CTRL_CMP] |=> state_r == ST_IDLE && !done_r)
        else $error("measurement ran with threshold function enabled");
    chk_start_capture: assert property (@(posedge clk) disable iff (rst) // [RULE_02]
        (arm_eff && state_r == ST_START && hi_fire)
        |=> start_cap_r == $past(fbus.fire_value))
        else $error("start capture missed buffered value");
    chk_end_capture: assert property (@(posedge clk) disable iff (rst) // [RULE_12]
        (arm_eff && state_r == ST_END && lo_fire)
        |=> end_cap_r == $past(fbus.fire_value) && done_r)
        else $error("end capture or done flag wrong");
    chk_high_only_end: assert property (@(posedge clk) disable iff (rst) // [RULE_06]
        (arm_eff && state_r == ST_START && hi_fire && mode_high_only(mode_r))
        |=> state_r == ST_DONE && done_r)
        else $error("high-only mode did not finish");
    chk_low_only_start: assert property (@(posedge clk) disable iff (rst) // [RULE_07]
        (state_r == ST_IDLE && arm_eff && mode_low_only(mode_r)) |=> state_r == ST_END)
        else $error("low-only mode did not wait for low level");
    chk_count_down: assert property (@(posedge clk) disable iff (rst) // [RULE_08]
        (enc_step && mode_r[0]) |=> pos_r == $past(pos_r) - 32'h0000_0001)
        else $error("odd mode did not count down");
    chk_disarm_clear: assert property (@(posedge clk) disable iff (rst) // [RULE_16]
        (!arm_eff ##1 !arm_eff) |-> !done_r && state_r == ST_IDLE && !fbus.pending)
        else $error("disarm left state behind");
    chk_sync_depth: assert property (@(posedge clk) disable iff (rst) // [RULE_17]
        $past(rst, 2) == 1'b0 |-> sync2_r == $past(latch_in, 2))
        else $error("latch synchroniser depth wrong");
    chk_done_source: assert property (@(posedge clk) disable iff (rst) // [RULE_05]
        $rose(done_r) |-> $past(fbus.fire))
        else $error("done set without filter expiry");
    chk_output_mux: assert property (@(posedge clk) disable iff (rst) // [RULE_13]
        ##1 out_drive == ($past(ctrl_r[CTRL_CMP]) ? $past(cmp_level)
                                                  : $past(ctrl_r[CTRL_SET])))
        else $error("output source wrong");

    cov_mode0_full: cover property (@(posedge clk) disable iff (rst)
        state_r == ST_END && mode_r == 3'h0 ##[1:1000] done_r);
    cov_glitch: cover property (@(posedge clk) disable iff (rst)
        fbus.pending ##1 !fbus.pending && !fbus.fire);
    cov_low_done: cover property (@(posedge clk) disable iff (rst)
        $rose(done_r) && mode_low_only(mode_r));
endmodule

// File: sim/latch_sensor.sv
// Behavioural workpiece sensor driving the latch pin and encoder increments
`timescale 1ns/1ps
module latch_sensor (
    input  wire logic clk,
    output logic      latch_in,
    output logic      enc_step
);
    ////////////////////////////////////////////////////////////////////////////
    // Idle: pin low, no increments
    initial begin
        latch_in = 1'b0;
        enc_step = 1'b0;
    end

    // Move the pin just after an edge; a quick second call makes a glitch
    task automatic set_level(input logic lvl);
        @(posedge clk);
        latch_in <= lvl;
    endtask

    // One-cycle increment pulses with a quiet cycle between them
    task automatic steps(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            enc_step <= 1'b1;
            @(posedge clk);
            enc_step <= 1'b0;
        end
    endtask
endmodule

// File: sim/workpiece_length_gauge_tb.sv
// Self-checking bench for the workpiece length gauge
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) begin \
            miscompares++; \
            $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
        end \
    end
module workpiece_length_gauge_tb;
    import gauge_pkg::*;

    localparam int         FILT     = 3;
    localparam logic [7:0] OFS_HOLE = 8'h1C;

    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        latch_in;
    logic        enc_step;
    logic        cmp_level;
    logic        out_drive;
    logic        meas_done;
    logic [31:0] rdat;
    logic        rerr;
    logic [31:0] c;
    int          miscompares;
    int          n_tests;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and design
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    workpiece_length_gauge u_workpiece_length_gauge (
        .clk       (clk),
        .rst       (rst),
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .paddr     (paddr),
        .pwdata    (pwdata),
        .prdata    (prdata),
        .pready    (pready),
        .pslverr   (pslverr),
        .latch_in  (latch_in),
        .enc_step  (enc_step),
        .cmp_level (cmp_level),
        .out_drive (out_drive),
        .meas_done (meas_done)
    );

    latch_sensor u_latch_sensor (
        .clk      (clk),
        .latch_in (latch_in),
        .enc_step (enc_step)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Verdict and bus tasks
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // One APB transfer: setup, access held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        @(posedge clk);
        while (pready !== 1'b1 && i < 50) begin
            i++;
            @(posedge clk);
        end
        if (i == 50) begin
            miscompares++;
            $display("[FAIL] pready expected 1 seen 0");
            give_verdict();
        end
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        `CHK(nm, exp, rdat)
    endtask

    // Change the pin; the capture word must move only on the last increment
    task automatic edge_cap(input logic lvl, input logic [7:0] cap, input string nm);
        logic [31:0] snap;
        logic [31:0] prev;
        apb(1'b0, cap, 32'h0);
        prev = rdat;
        apb(1'b0, OFS_COUNT, 32'h0);
        snap = rdat;
        u_latch_sensor.set_level(lvl);
        repeat (5) @(posedge clk);
        u_latch_sensor.steps(FILT - 1);
        repeat (8) @(posedge clk);
        rd_chk(cap, prev, nm);
        u_latch_sensor.steps(1);
        repeat (8) @(posedge clk);
        rd_chk(cap, snap, nm);
    endtask

    // Full sequence of one mode, then the counting direction
    task automatic run_mode(input logic [2:0] m);
        logic [31:0] c0;
        apb(1'b1, OFS_CTRL, 32'h0);
        // Disarm lands at the access edge; done drops one edge later
        repeat (2) @(posedge clk);
        `CHK("done cleared", 1'b0, meas_done)
        u_latch_sensor.set_level(m >= 3'h4);
        apb(1'b1, OFS_MODE, {29'h0, m});
        apb(1'b1, OFS_CTRL, 32'h1);
        if (m < 3'h4) begin
            edge_cap(1'b1, OFS_START, "start capture");
        end
        if (m < 3'h2) begin
            `CHK("done after start", 1'b0, meas_done)
            edge_cap(1'b0, OFS_END, "end capture");
        end
        if (m >= 3'h4) begin
            u_latch_sensor.steps(FILT);
            repeat (8) @(posedge clk);
            `CHK("done before low", 1'b0, meas_done)
            edge_cap(1'b0, OFS_END, "low capture");
        end
        `CHK("done flag", 1'b1, meas_done)
        apb(1'b0, OFS_COUNT, 32'h0);
        c0 = rdat;
        u_latch_sensor.steps(4);
        rd_chk(OFS_COUNT, m[0] ? c0 - 32'h4 : c0 + 32'h4, "count direction");
        $display("Mode %0d test done", m);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        cmp_level = 1'b0;
        miscompares = 0;
        n_tests = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;

        // Reset values and an unmapped place
        for (int i = 0; i < 6; i++) begin
            rd_chk(8'(4 * i), ZERO_WORD, "reset value");
        end
        rd_chk(OFS_HOLE, ZERO_WORD, "unmapped read");
        `CHK("unmapped read err", 1'b1, rerr)
        apb(1'b1, OFS_HOLE, 32'hFFFF_FFFF);
        `CHK("unmapped write err", 1'b1, rerr)
        apb(1'b1, OFS_FILTER, 32'(FILT));
        rd_chk(OFS_FILTER, 32'(FILT), "filter value");
        $display("Register test done");

        // Every mode
        for (int m = 0; m < 6; m++) begin
            run_mode(3'(m));
        end

        // Glitch inside the filter window is dropped, the next edge is taken
        apb(1'b1, OFS_CTRL, 32'h0);
        u_latch_sensor.set_level(1'b0);
        apb(1'b1, OFS_MODE, 32'h0);
        apb(1'b1, OFS_CTRL, 32'h1);
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK("busy flag", 1'b1, rdat[STS_BUSY])
        apb(1'b0, OFS_START, 32'h0);
        c = rdat;
        u_latch_sensor.set_level(1'b1);
        repeat (5) @(posedge clk);
        u_latch_sensor.steps(1);
        u_latch_sensor.set_level(1'b0);
        repeat (5) @(posedge clk);
        u_latch_sensor.steps(FILT);
        repeat (8) @(posedge clk);
        rd_chk(OFS_START, c, "glitch dropped");
        edge_cap(1'b1, OFS_START, "start after glitch");
        $display("Glitch test done");

        // Pin already high when armed
        apb(1'b1, OFS_CTRL, 32'h0);
        apb(1'b1, OFS_MODE, 32'h1);
        apb(1'b0, OFS_COUNT, 32'h0);
        c = rdat;
        apb(1'b1, OFS_CTRL, 32'h1);
        u_latch_sensor.steps(FILT);
        repeat (8) @(posedge clk);
        rd_chk(OFS_START, c, "start at arm");
        $display("Armed high test done");

        // Arming refused beside the threshold function or with a bad mode
        apb(1'b1, OFS_CTRL, 32'h0);
        apb(1'b1, OFS_MODE, 32'h2);
        apb(1'b1, OFS_CTRL, 32'h3);
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK("conflict flag", 1'b1, rdat[STS_CFGERR])
        u_latch_sensor.set_level(1'b0);
        u_latch_sensor.set_level(1'b1);
        u_latch_sensor.steps(FILT + 2);
        repeat (8) @(posedge clk);
        `CHK("no done when refused", 1'b0, meas_done)
        apb(1'b1, OFS_CTRL, 32'h0);
        apb(1'b1, OFS_MODE, 32'h6);
        apb(1'b1, OFS_CTRL, 32'h1);
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK("bad mode flag", 1'b1, rdat[STS_BADMOD])
        $display("Refusal test done");

        // Output by the manual bit, then by the threshold level
        apb(1'b1, OFS_CTRL, 32'h4);
        repeat (3) @(posedge clk);
        `CHK("manual output on", 1'b1, out_drive)
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK("output status", 1'b1, rdat[STS_OUT])
        apb(1'b1, OFS_CTRL, 32'h2);
        cmp_level <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK("threshold output on", 1'b1, out_drive)
        cmp_level <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK("threshold output off", 1'b0, out_drive)
        $display("Output test done");
        give_verdict();
    end
endmodule
